// ===== logic/fsc_defs.vh
// constants for the field sensor control register bank
`ifndef FSC_DEFS_VH
`define FSC_DEFS_VH
`define FSC_OFS_ID0        6'h00
`define FSC_OFS_ID1        6'h01
`define FSC_OFS_OPCTL      6'h32
`define FSC_OFS_THR        6'h36
`define FSC_OFS_AXIS       6'h38
`define FSC_OFS_FILT       6'h3a
`define FSC_OFS_RSVD       6'h3c
`define FSC_OFS_KEY        6'h3e
`define FSC_MASK_THR       16'h0fff
`define FSC_MASK_AXIS      16'h3f7f
`define FSC_MASK_FILT      16'h077f
`define FSC_RST_WORD       16'h0000
`define FSC_BIT_START      12
`define FSC_BIT_IFLAG      11
`define FSC_BIT_READY      10
`define FSC_DOZE_HI        6
`define FSC_DOZE_LO        4
`define FSC_PCFG_HI        3
`define FSC_PCFG_LO        1
`define FSC_AX_OFF_HI      13
`define FSC_AX_OFF_LO      11
`define FSC_AX_INV_HI      10
`define FSC_AX_INV_LO      8
`define FSC_ISEL_HI        6
`define FSC_ISEL_LO        3
`define FSC_BIT_ISIGN      2
`define FSC_BIT_PLATCH     1
`define FSC_BIT_PPOL       0
`define FSC_LPBW_HI        10
`define FSC_LPBW_LO        8
`define FSC_ACBW_HI        6
`define FSC_ACBW_LO        4
`define FSC_BIT_ADIR       3
`define FSC_PLANE_HI       2
`define FSC_PLANE_LO       0
`define FSC_MODE_ACT_MAX   3'h2
`define FSC_MODE_LP_A      3'h3
`define FSC_MODE_LP_B      3'h4
`define FSC_ISEL_PIN       4'h0
`define FSC_ISEL_X         4'h1
`define FSC_ISEL_Y         4'h2
`define FSC_ISEL_Z         4'h3
`define FSC_ISEL_ANGLE     4'h4
`define FSC_CMD_LAST       6'h0f
`define FSC_WR_LAST        6'h1f
`define FSC_CNT_MAX        6'h3f
`define FSC_BIT_RD         15
`define FSC_BIT_IND        14
`define FSC_ADDR_HI        13
`define FSC_ADDR_LO        8
`define FSC_ECC_HI         31
`define FSC_ECC_LO         26
`define FSC_TAG_HI         25
`define FSC_TAG_LO         22
`endif

// ===== logic/fsc_id_rows.v
// two read-only identification rows with registered read data and check flags
`timescale 1ns/1ps
`default_nettype none
`include "fsc_defs.vh"
module fsc_id_rows #(
   parameter [3:0]  TAG_ZERO  = 4'h5,      // arbitrary value
   parameter [3:0]  TAG_ONE   = 4'ha,      // arbitrary value
   parameter [21:0] BODY_ZERO = 22'h000000,
   parameter [21:0] BODY_ONE  = 22'h000000
) (
   input  wire        clk,
   input  wire        rst,
   input  wire        rd_en,
   input  wire        row_sel,
   output reg  [31:0] rd_data
);
   wire [25:0] row0 = {TAG_ZERO, BODY_ZERO};
   wire [25:0] row1 = {TAG_ONE, BODY_ONE};
   // check bits stored with each row; a mismatch on read raises a flag
   localparam P0 = ^{TAG_ZERO, BODY_ZERO};
   localparam P1 = ^{TAG_ONE, BODY_ONE};
   wire [25:0] row = row_sel ? row1 : row0;
   wire        chk = row_sel ? P1 : P0;
   wire        err = (^row) ^ chk;
   always @(posedge clk) begin
      if (rst) begin
         rd_data <= 32'h00000000;
      end else if (rd_en) begin
         rd_data <= {5'h00, err, row};
      end
   end
endmodule
`default_nettype wire

// ===== logic/fsc_ctrl_regs.v
// control register bank of the field sensor behind its serial port
// Operation
// - start bit launches conversion when ready and busy are both clear
// - idle in standby until start bit or pin
// - interrupt flag latches until host writes zero
// - ready flag latches on done until cleared
// - doze interval applies in duty-cycle mode
// - mode field selects power configuration
// - threshold is four high plus eight low bits
// - axis off bits remove channel from processing
// - axis invert bits negate channel value
// - select field chooses compared signal
// - sign bit picks below or above threshold
// - latch bit holds pin after condition ends
// - polarity bit picks pin active level
// - low-power bandwidth used in modes three, four
// - active bandwidth used in modes zero to two and five to seven
// - direction bit sets angle code sense
// - plane field picks angle channel pair
// - direct bits mirror shadow parameters
// - access word accepts unlock code
// - identity rows carry error flag bits
// - row zero holds four-bit factory tag
// - modes split active, duty-cycle and sleep
`timescale 1ns/1ps
`default_nettype none
`include "fsc_defs.vh"
module fsc_ctrl_regs #(
   parameter [15:0] UNLOCK_KEY = 16'h5a5a,  // arbitrary value
   parameter        VAL_W      = 12
) (
   input  wire             MCLK,
   input  wire             RST,
   input  wire             SCLK,
   input  wire             CS_N,
   input  wire             MOSI,
   output reg              MISO,
   output reg              MISO_OE_N,
   input  wire             SAMPLE_PIN_IN,
   output reg              SAMPLE_PIN_OUT,
   output reg              SAMPLE_PIN_OE_N,
   input  wire [VAL_W-1:0] X_VALUE,
   input  wire [VAL_W-1:0] Y_VALUE,
   input  wire [VAL_W-1:0] Z_VALUE,
   input  wire [VAL_W-1:0] ANGLE_VALUE,
   input  wire             CONV_DONE,
   output reg              CONV_START,
   output reg  [2:0]       CONV_CHANNELS,
   output reg              STANDBY,
   output reg  [2:0]       POWER_CONFIG,
   output reg              MODE_ACTIVE,
   output reg              MODE_DUTY_CYCLE,
   output reg              MODE_SLEEP,
   output reg  [2:0]       DOZE_INTERVAL,
   output reg  [2:0]       BANDWIDTH_SEL,
   output reg  [2:0]       AXIS_INVERT,
   output reg              ANGLE_DIRECTION,
   output reg  [2:0]       ANGLE_PLANE,
   output reg              MEM_UNLOCKED
);
   // control words
   reg  [2:0]       doze_interval;
   reg  [2:0]       power_config;
   reg  [15:0]      thr_word;
   reg  [15:0]      axis_word;
   reg  [15:0]      filt_word;
   reg  [15:0]      rsvd_word;
   reg              int_flag;
   reg              ready;
   reg              busy;
   // serial port state
   reg  [2:0]       sclk_s;
   reg  [2:0]       cs_s;
   reg  [1:0]       mosi_s;
   reg  [2:0]       pin_s;
   reg  [5:0]       cnt;
   reg  [31:0]      sh_in;
   reg  [31:0]      sh_out;
   reg  [15:0]      cmd;
   reg              id_load;
   wire [31:0]      id_data;
   wire             sclk_rise = sclk_s[1] & ~sclk_s[2];
   wire             sclk_fall = ~sclk_s[1] & sclk_s[2];
   wire             active    = ~cs_s[1];
   wire             bit_in    = mosi_s[1];
   wire [15:0]      next_cmd  = {sh_in[14:0], bit_in};
   wire             cmd_done  = active & sclk_rise & (cnt == `FSC_CMD_LAST);
   wire             wr_done   = active & sclk_rise & (cnt == `FSC_WR_LAST) & ~cmd[`FSC_BIT_RD];
   wire [5:0]       wr_addr   = cmd[`FSC_ADDR_HI:`FSC_ADDR_LO];
   wire             wr_direct = wr_done & ~cmd[`FSC_BIT_IND];
   wire             wr_opctl  = wr_direct & (wr_addr == `FSC_OFS_OPCTL);

   // named fields
   wire [3:0]       alert_level_hi = thr_word[11:8];
   wire [7:0]       alert_level_lo = thr_word[7:0];
   wire [2:0]       axis_off       = axis_word[`FSC_AX_OFF_HI:`FSC_AX_OFF_LO];
   wire [2:0]       axis_invert    = axis_word[`FSC_AX_INV_HI:`FSC_AX_INV_LO];
   wire [3:0]       alert_select   = axis_word[`FSC_ISEL_HI:`FSC_ISEL_LO];
   wire             alert_sign     = axis_word[`FSC_BIT_ISIGN];
   wire             pin_latch      = axis_word[`FSC_BIT_PLATCH];
   wire             pin_polarity   = axis_word[`FSC_BIT_PPOL];
   wire [2:0]       lowpower_bandwidth = filt_word[`FSC_LPBW_HI:`FSC_LPBW_LO];
   wire [2:0]       active_bandwidth   = filt_word[`FSC_ACBW_HI:`FSC_ACBW_LO];
   wire             duty_cycle_lowpower = (power_config == `FSC_MODE_LP_A) |
                                          (power_config == `FSC_MODE_LP_B);
   wire             pin_mode       = (alert_select == `FSC_ISEL_PIN);

   // register read mux, fixed-zero bits come back as zero
   function [15:0] dir_read;
      input [5:0] a;
      begin
         case (a)
            `FSC_OFS_OPCTL: dir_read = {3'h0, busy, int_flag, ready, 3'h0,
                                        doze_interval, power_config, 1'b0};
            `FSC_OFS_THR:   dir_read = thr_word;
            `FSC_OFS_AXIS:  dir_read = axis_word;
            `FSC_OFS_FILT:  dir_read = filt_word;
            `FSC_OFS_RSVD:  dir_read = rsvd_word;
            default:        dir_read = 16'h0000;
         endcase
      end
   endfunction

   // optional sign flip of a channel, then compare against the threshold
   function [VAL_W-1:0] cond_val;
      input [VAL_W-1:0] v;
      input             inv;
      begin
         cond_val = inv ? (~v + {{(VAL_W-1){1'b0}}, 1'b1}) : v;
      end
   endfunction

   reg  [VAL_W-1:0] sel_val;
   reg              sel_ok;
   always @* begin
      sel_val = {VAL_W{1'b0}};
      sel_ok  = 1'b0;
      case (alert_select)
         `FSC_ISEL_X: begin
            sel_val = cond_val(X_VALUE, axis_invert[0]);
            sel_ok  = ~axis_off[0];
         end
         `FSC_ISEL_Y: begin
            sel_val = cond_val(Y_VALUE, axis_invert[1]);
            sel_ok  = ~axis_off[1];
         end
         `FSC_ISEL_Z: begin
            sel_val = cond_val(Z_VALUE, axis_invert[2]);
            sel_ok  = ~axis_off[2];
         end
         `FSC_ISEL_ANGLE: begin
            sel_val = ANGLE_VALUE;
            sel_ok  = 1'b1;
         end
         default: begin
            sel_val = {VAL_W{1'b0}};
            sel_ok  = 1'b0;
         end
      endcase
   end

   wire signed [VAL_W-1:0] s_val = sel_val;
   wire signed [11:0]      s_thr = {alert_level_hi, alert_level_lo};
   wire                    above = s_val > s_thr;
   wire                    below = s_val < s_thr;
   wire                    cond  = sel_ok & (alert_sign ? above : below);
   // polarity applied past the flops so a polarity write cannot fake an edge
   wire                    pin_now  = pin_s[1] ~^ pin_polarity;
   wire                    pin_prev = pin_s[2] ~^ pin_polarity;
   wire                    pin_hit  = pin_now & ~pin_prev;
   wire                    pin_start = pin_mode & pin_hit;
   wire                    start_wr = wr_opctl & sh_in[`FSC_BIT_START - 1];
   // a pin edge while busy or ready is dropped, not queued
   wire                    launch = ~ready & ~busy & (start_wr | pin_start);

   // synchronisers: SCLK, CS_N, MOSI and the pin are asynchronous to MCLK
   always @(posedge MCLK) begin
      if (RST) begin
         sclk_s <= 3'h0;
         cs_s   <= 3'h7;
         mosi_s <= 2'h0;
         pin_s  <= 3'h7;
      end else begin
         sclk_s <= {sclk_s[1:0], SCLK};
         cs_s   <= {cs_s[1:0], CS_N};
         mosi_s <= {mosi_s[0], MOSI};
         // raw level; polarity is applied past the second flop
         pin_s  <= {pin_s[1:0], SAMPLE_PIN_IN};
      end
   end

   // serial frame: 16-bit command then data, mode 0
   always @(posedge MCLK) begin
      if (RST) begin
         cnt       <= 6'h00;
         sh_in     <= 32'h00000000;
         sh_out    <= 32'h00000000;
         cmd       <= 16'h0000;
         id_load   <= 1'b0;
         MISO      <= 1'b0;
         MISO_OE_N <= 1'b1;
      end else begin
         id_load <= 1'b0;
         if (!active) begin
            cnt       <= 6'h00;
            MISO_OE_N <= 1'b1;
            MISO      <= 1'b0;
         end else begin
            if (sclk_rise) begin
               sh_in <= {sh_in[30:0], bit_in};
               // count saturates, so bits past the top are ignored
               if (cnt != `FSC_CNT_MAX) begin
                  cnt <= cnt + 6'h01;
               end
            end
            if (cmd_done) begin
               cmd <= next_cmd;
               if (!next_cmd[`FSC_BIT_IND]) begin
                  sh_out <= {dir_read(next_cmd[`FSC_ADDR_HI:`FSC_ADDR_LO]), 16'h0000};
               end else begin
                  id_load <= 1'b1;
               end
            end else if (id_load) begin
               // indirect rows stay hidden until the access code is taken
               sh_out <= MEM_UNLOCKED ? id_data : 32'h00000000;
            end else if (sclk_fall && cnt > `FSC_CMD_LAST && cmd[`FSC_BIT_RD]) begin
               MISO      <= sh_out[31];
               MISO_OE_N <= 1'b0;
               sh_out    <= {sh_out[30:0], 1'b0};
            end
         end
      end
   end

   fsc_id_rows u_rows (
      .clk     (MCLK),
      .rst     (RST),
      .rd_en   (cmd_done),
      .row_sel (next_cmd[`FSC_ADDR_LO]),
      .rd_data (id_data)
   );

   // register writes, only writable bits are kept
   always @(posedge MCLK) begin
      if (RST) begin
         doze_interval <= 3'h0;
         power_config  <= 3'h0;
         thr_word      <= `FSC_RST_WORD;
         axis_word     <= `FSC_RST_WORD;
         filt_word     <= `FSC_RST_WORD;
         rsvd_word     <= `FSC_RST_WORD;
         MEM_UNLOCKED  <= 1'b0;
      end else if (wr_direct) begin
         case (wr_addr)
            `FSC_OFS_OPCTL: begin
               doze_interval <= sh_in[`FSC_DOZE_HI-1:`FSC_DOZE_LO-1];
               power_config  <= sh_in[`FSC_PCFG_HI-1:`FSC_PCFG_LO-1];
            end
            `FSC_OFS_THR:  thr_word  <= {sh_in[14:0], bit_in} & `FSC_MASK_THR;
            `FSC_OFS_AXIS: axis_word <= {sh_in[14:0], bit_in} & `FSC_MASK_AXIS;
            `FSC_OFS_FILT: filt_word <= {sh_in[14:0], bit_in} & `FSC_MASK_FILT;
            // held as written; the host is expected to leave it at zero
            `FSC_OFS_RSVD: rsvd_word <= {sh_in[14:0], bit_in};
            // a wrong key locks again; only the last key write counts
            `FSC_OFS_KEY:  MEM_UNLOCKED <= ({sh_in[14:0], bit_in} == UNLOCK_KEY);
            default: begin
            end
         endcase
      end
   end

   // latched flags: hardware set wins over a host clear in the same cycle
   always @(posedge MCLK) begin
      if (RST) begin
         ready      <= 1'b0;
         int_flag   <= 1'b0;
         busy       <= 1'b0;
         CONV_START <= 1'b0;
      end else begin
         CONV_START <= launch;
         if (launch) begin
            busy <= 1'b1;
         end else if (CONV_DONE) begin
            busy <= 1'b0;
         end
         if (busy && CONV_DONE) begin
            ready <= 1'b1;
         end else if (wr_opctl && !sh_in[`FSC_BIT_READY - 1]) begin
            ready <= 1'b0;
         end
         if (cond) begin
            int_flag <= 1'b1;
         end else if (wr_opctl && !sh_in[`FSC_BIT_IFLAG - 1]) begin
            int_flag <= 1'b0;
         end
      end
   end

   // configuration and pin outputs
   // one register stage on every output keeps them glitch free
   always @(posedge MCLK) begin
      if (RST) begin
         CONV_CHANNELS   <= 3'h7;
         STANDBY         <= 1'b1;
         POWER_CONFIG    <= 3'h0;
         MODE_ACTIVE     <= 1'b1;
         MODE_DUTY_CYCLE <= 1'b0;
         MODE_SLEEP      <= 1'b0;
         DOZE_INTERVAL   <= 3'h0;
         BANDWIDTH_SEL   <= 3'h0;
         AXIS_INVERT     <= 3'h0;
         ANGLE_DIRECTION <= 1'b0;
         ANGLE_PLANE     <= 3'h0;
         SAMPLE_PIN_OUT  <= 1'b1;
         SAMPLE_PIN_OE_N <= 1'b1;
      end else begin
         CONV_CHANNELS   <= ~axis_off;
         STANDBY         <= ~busy & ~launch;
         POWER_CONFIG    <= power_config;
         MODE_ACTIVE     <= (power_config <= `FSC_MODE_ACT_MAX);
         MODE_DUTY_CYCLE <= duty_cycle_lowpower;
         // codes above the duty-cycle pair all mean sleep
         MODE_SLEEP      <= (power_config > `FSC_MODE_LP_B);
         // interval has no meaning outside duty cycling, so it reads zero there
         DOZE_INTERVAL   <= duty_cycle_lowpower ? doze_interval : 3'h0;
         BANDWIDTH_SEL   <= duty_cycle_lowpower ? lowpower_bandwidth
                                                : active_bandwidth;
         AXIS_INVERT     <= axis_invert;
         ANGLE_DIRECTION <= filt_word[`FSC_BIT_ADIR];
         ANGLE_PLANE     <= filt_word[`FSC_PLANE_HI:`FSC_PLANE_LO];
         SAMPLE_PIN_OE_N <= pin_mode;
         SAMPLE_PIN_OUT  <= (cond | (pin_latch & int_flag)) ~^ pin_polarity;
      end
   end
endmodule
`default_nettype wire

// ===== dv/fsc_ctrl_regs_checker.sv
// assertion checker for the field sensor control registers
`timescale 1ns/1ps
`default_nettype none
module fsc_ctrl_regs_checker (
   input wire logic       MCLK,
   input wire logic       RST,
   input wire logic       CS_N,
   input wire logic       CONV_START,
   input wire logic       STANDBY,
   input wire logic [2:0] POWER_CONFIG,
   input wire logic       MODE_ACTIVE,
   input wire logic       MODE_DUTY_CYCLE,
   input wire logic       MODE_SLEEP,
   input wire logic [2:0] DOZE_INTERVAL,
   input wire logic [2:0] CONV_CHANNELS,
   input wire logic       MEM_UNLOCKED
);
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (RST);
   a_start_one_pulse: assert property (CONV_START |=> !CONV_START)
      else $error("start pulse longer than one cycle");
   a_start_from_idle: assert property (CONV_START |-> $past(STANDBY))
      else $error("start while a conversion runs");
   a_start_ends_idle: assert property (CONV_START |=> !STANDBY)
      else $error("standby kept after start");
   a_idle_left_start: assert property ($fell(STANDBY) |-> CONV_START)
      else $error("standby left without start");
   a_mode_active_dec: assert property (MODE_ACTIVE == (POWER_CONFIG <= 3'h2))
      else $error("active mode decode wrong");
   a_mode_one_hot: assert property ($onehot({MODE_ACTIVE, MODE_DUTY_CYCLE, MODE_SLEEP}))
      else $error("mode levels not one hot");
   a_doze_duty_only: assert property (!MODE_DUTY_CYCLE |-> DOZE_INTERVAL == 3'h0)
      else $error("doze interval outside duty cycle");
   a_channels_by_frame: assert property ($changed(CONV_CHANNELS) |-> !$past(CS_N))
      else $error("channel set changed outside a frame");
   a_unlock_by_frame: assert property ($changed(MEM_UNLOCKED) |-> !$past(CS_N))
      else $error("unlock changed outside a frame");
   c_start: cover property (CONV_START);
   c_unlock: cover property ($rose(MEM_UNLOCKED));
   c_doze: cover property (MODE_DUTY_CYCLE && DOZE_INTERVAL != 3'h0);
endmodule
bind fsc_ctrl_regs fsc_ctrl_regs_checker i_fsc_ctrl_regs_checker (
   .MCLK(MCLK), .RST(RST), .CS_N(CS_N), .CONV_START(CONV_START), .STANDBY(STANDBY),
   .POWER_CONFIG(POWER_CONFIG), .MODE_ACTIVE(MODE_ACTIVE), .MODE_DUTY_CYCLE(MODE_DUTY_CYCLE),
   .MODE_SLEEP(MODE_SLEEP), .DOZE_INTERVAL(DOZE_INTERVAL), .CONV_CHANNELS(CONV_CHANNELS),
   .MEM_UNLOCKED(MEM_UNLOCKED));
`default_nettype wire

// ===== dv/fsc_host_model.sv
// host side serial master model for the field sensor control registers
`timescale 1ns/1ps
`default_nettype none
module fsc_host_model (
   output var logic SCLK,
   output var logic CS_N,
   output var logic MOSI,
   input  wire logic MISO,
   input  wire logic MISO_OE_N
);
   initial begin
      SCLK = 1'b0;
      CS_N = 1'b1;
      MOSI = 1'b0;
   end
   // mode 0, msb first; clock rests low between frames
   task automatic frame(input logic [47:0] tx, input int n, output logic [47:0] rx);
      rx = '0;
      // step off the clock grid so no pin moves on a system clock edge
      #1.25 CS_N = 1'b0;
      #24;
      for (int i = n - 1; i >= 0; i--) begin
         MOSI = tx[i];
         #24 SCLK = 1'b1;
         rx[i] = (MISO_OE_N === 1'b0) ? MISO : 1'bx;
         #24 SCLK = 1'b0;
      end
      #24 CS_N = 1'b1;
      // released line flips so a stale bit never passes for data
      MOSI = ~MOSI;
      #28.75;
   endtask
endmodule
`default_nettype wire

// ===== dv/fsc_ctrl_regs_tb.sv
// self-checking bench for the field sensor control registers
`timescale 1ns/1ps
`default_nettype none
module fsc_ctrl_regs_tb;
   logic MCLK, RST = 1'b1, CONV_DONE = 1'b0, ext_pin = 1'b1;
   logic [11:0] X_VALUE = 12'h000, Y_VALUE = 12'h000, Z_VALUE = 12'h000, ANGLE_VALUE = 12'h000;
   wire logic SCLK, CS_N, MOSI, MISO, MISO_OE_N, SAMPLE_PIN_OUT, SAMPLE_PIN_OE_N, CONV_START;
   wire logic STANDBY, MODE_ACTIVE, MODE_DUTY_CYCLE, MODE_SLEEP, ANGLE_DIRECTION, MEM_UNLOCKED;
   wire logic [2:0] CONV_CHANNELS, POWER_CONFIG, DOZE_INTERVAL, BANDWIDTH_SEL, AXIS_INVERT;
   wire logic [2:0] ANGLE_PLANE;
   // shared pin: outside pull-up level unless the block drives it
   wire logic SAMPLE_PIN_IN = SAMPLE_PIN_OE_N ? ext_pin : SAMPLE_PIN_OUT;
   int fail_count = 0, check_count = 0, starts = 0, n;
   logic [47:0] r;
   logic [5:0] ofs [6] = '{6'h32, 6'h36, 6'h38, 6'h3a, 6'h3c, 6'h3e};
   logic [15:0] msk [4] = '{16'h0000, 16'h0fff, 16'h3f7f, 16'h077f};
   fsc_ctrl_regs i_fsc_ctrl_regs (.MCLK(MCLK), .RST(RST), .SCLK(SCLK), .CS_N(CS_N),
      .MOSI(MOSI), .MISO(MISO), .MISO_OE_N(MISO_OE_N), .SAMPLE_PIN_IN(SAMPLE_PIN_IN),
      .SAMPLE_PIN_OUT(SAMPLE_PIN_OUT), .SAMPLE_PIN_OE_N(SAMPLE_PIN_OE_N), .X_VALUE(X_VALUE),
      .Y_VALUE(Y_VALUE), .Z_VALUE(Z_VALUE), .ANGLE_VALUE(ANGLE_VALUE), .CONV_DONE(CONV_DONE),
      .CONV_START(CONV_START), .CONV_CHANNELS(CONV_CHANNELS), .STANDBY(STANDBY),
      .POWER_CONFIG(POWER_CONFIG), .MODE_ACTIVE(MODE_ACTIVE), .MODE_DUTY_CYCLE(MODE_DUTY_CYCLE),
      .MODE_SLEEP(MODE_SLEEP), .DOZE_INTERVAL(DOZE_INTERVAL), .BANDWIDTH_SEL(BANDWIDTH_SEL),
      .AXIS_INVERT(AXIS_INVERT), .ANGLE_DIRECTION(ANGLE_DIRECTION), .ANGLE_PLANE(ANGLE_PLANE),
      .MEM_UNLOCKED(MEM_UNLOCKED));
   fsc_host_model u_host (.SCLK(SCLK), .CS_N(CS_N), .MOSI(MOSI), .MISO(MISO),
      .MISO_OE_N(MISO_OE_N));
   initial begin
      MCLK = 1'b0;
      forever #2.5 MCLK = ~MCLK;
   end
   always @(posedge MCLK) if (CONV_START === 1'b1) starts <= starts + 1;
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      check_count++;
      if (s !== e) begin
         fail_count++;
         $display("unexpected at %0t: saw %h want %h", $time, s, e);
      end
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic wr(input logic [5:0] a, input logic [15:0] d);
      u_host.frame({16'h0, 2'b00, a, 8'h00, d}, 32, r);
   endtask
   task automatic rd(input logic [5:0] a, input logic [15:0] e);
      u_host.frame({16'h0, 2'b10, a, 8'h00, 16'h0}, 32, r);
      chk(r[15:0], e);
   endtask
   task automatic done();
      @(posedge MCLK) CONV_DONE <= 1'b1;
      @(posedge MCLK) CONV_DONE <= 1'b0;
      repeat (2) @(posedge MCLK);
   endtask
   // bounded wait; running out ends the run
   task automatic wait_start(input int t);
      for (int i = 0; i < 20 && starts != t; i++) @(posedge MCLK);
      chk(starts, t);
      if (starts != t) tally_and_finish();
   endtask
   initial begin
      repeat (5) @(posedge MCLK);
      RST <= 1'b0;
      repeat (3) @(posedge MCLK);
      for (int i = 0; i < 6; i++) rd(ofs[i], 16'h0000);
      chk({CONV_CHANNELS, STANDBY, MODE_ACTIVE, SAMPLE_PIN_OE_N}, 6'h3f);
      for (int i = 1; i < 4; i++) begin
         wr(ofs[i], 16'hffff);
         rd(ofs[i], msk[i]);
      end
      chk({CONV_CHANNELS, AXIS_INVERT, ANGLE_DIRECTION, ANGLE_PLANE}, 10'h07f);
      wr(6'h20, 16'hffff);
      rd(6'h20, 16'h0000);
      $display("test reset and masks done");
      wr(6'h3a, 16'h0635);
      chk({ANGLE_DIRECTION, ANGLE_PLANE}, 4'h5);
      for (int m = 0; m < 8; m++) begin
         wr(6'h32, {9'h0, 3'h5, m[2:0], 1'b0});
         chk(POWER_CONFIG, m[2:0]);
         chk({MODE_ACTIVE, MODE_DUTY_CYCLE, MODE_SLEEP}, {m < 3, m == 3 || m == 4, m > 4});
         chk({DOZE_INTERVAL, BANDWIDTH_SEL}, (m == 3 || m == 4) ? 6'o56 : 6'o03);
      end
      $display("test modes done");
      wr(6'h32, 16'h0000);
      wr(6'h38, 16'h0000);
      n = starts;
      wr(6'h32, 16'h1000);
      chk({starts, STANDBY}, {n + 1, 1'b0});
      rd(6'h32, 16'h1000);
      done();
      rd(6'h32, 16'h0400);
      wr(6'h32, 16'h1400);
      chk(starts, n + 1);
      rd(6'h32, 16'h0400);
      wr(6'h32, 16'h0000);
      rd(6'h32, 16'h0000);
      @(posedge MCLK) ext_pin <= 1'b0;
      wait_start(n + 2);
      @(posedge MCLK) ext_pin <= 1'b1;
      done();
      wr(6'h32, 16'h0000);
      $display("test conversion done");
      wr(6'h36, 16'h0100);
      wr(6'h38, 16'h0008);
      @(posedge MCLK) X_VALUE <= 12'h050;
      repeat (4) @(posedge MCLK);
      chk({SAMPLE_PIN_OE_N, SAMPLE_PIN_OUT}, 2'b00);
      @(posedge MCLK) X_VALUE <= 12'h200;
      repeat (4) @(posedge MCLK);
      chk({SAMPLE_PIN_OE_N, SAMPLE_PIN_OUT}, 2'b01);
      rd(6'h32, 16'h0800);
      wr(6'h38, 16'h000b);
      chk(SAMPLE_PIN_OUT, 1'b1);
      wr(6'h32, 16'h0000);
      rd(6'h32, 16'h0000);
      chk(SAMPLE_PIN_OUT, 1'b0);
      wr(6'h38, 16'h000c);
      rd(6'h32, 16'h0800);
      wr(6'h38, 16'h010c);
      wr(6'h32, 16'h0000);
      rd(6'h32, 16'h0000);
      wr(6'h38, 16'h080c);
      rd(6'h32, 16'h0000);
      // y, z and angle selects with above sense, z held at zero; a live condition beats the clear
      @(posedge MCLK) {Y_VALUE, ANGLE_VALUE} <= {12'h300, 12'h300};
      for (int s = 2; s < 5; s++) begin
         wr(6'h38, {9'h0, s[3:0], 3'b100});
         wr(6'h32, 16'h0000);
         rd(6'h32, (s == 3) ? 16'h0000 : 16'h0800);
      end
      $display("test interrupt done");
      // locked indirect read returns zero; once unlocked, row zero shows its tag
      u_host.frame({16'hc000, 32'h0}, 48, r);
      chk(r[31:0], 32'h0);
      wr(6'h3e, 16'h5a5a);
      chk(MEM_UNLOCKED, 1'b1);
      rd(6'h3e, 16'h0000);
      u_host.frame({16'hc000, 32'h0}, 48, r);
      chk(r[31:26], 6'h00);
      chk(r[25:22], 4'h5);
      wr(6'h3e, 16'h1111);
      chk(MEM_UNLOCKED, 1'b0);
      $display("test unlock done");
      tally_and_finish();
   end
endmodule
`default_nettype wire
